// file: dsp_pkg.sv
// Constants, register layout and carrier types of the dual serial port.
// Assumes one system clock; all users reference items as dsp_pkg::name.
package dsp_pkg;

  // System clock rate and receiver oversampling factor.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned OVS = 16;

  // Register offsets inside one channel; bit 4 of the address picks it.
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [3:0] OFF_TX = 4'h4;
  localparam logic [3:0] OFF_RX = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hc;
  localparam int CH_SEL_BIT = 4;

  // Configuration field positions.
  localparam int CFG_EN = 0;
  localparam int CFG_BAUD = 1;
  localparam int CFG_EIGHT = 4;
  localparam int CFG_PAR = 5;
  localparam int CFG_STOP = 8;
  localparam int CFG_HW = 10;

  // Status field positions; error bits are write-one-to-clear.
  localparam int ST_RXV = 0;
  localparam int ST_TXF = 1;
  localparam int ST_PERR = 2;
  localparam int ST_FERR = 3;
  localparam int ST_OVR = 4;
  localparam int ST_PXOFF = 5;
  localparam int ST_SRQ = 6;
  localparam int ST_REM = 7;
  localparam int ST_SRQ_GO = 8;

  // Parity and stop period codes.
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_ZERO = 3'h3;
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_15 = 2'h1;

  // Oversample tick counts inside one bit and for each stop period.
  localparam logic [5:0] TK_MID = 6'h07;
  localparam logic [5:0] TK_LAST = 6'h0f;
  localparam logic [5:0] TK_STOP_1 = 6'h10;
  localparam logic [5:0] TK_STOP_15 = 6'h18;
  localparam logic [5:0] TK_STOP_2 = 6'h20;

  // Flow characters and in-band control strings, first character high.
  localparam logic [7:0] CHR_XON = 8'h11;
  localparam logic [7:0] CHR_XOFF = 8'h13;
  localparam logic [31:0] STR_REMOTE = 32'h4052454d;
  localparam logic [31:0] STR_MANUAL = 32'h404c4f43;
  localparam logic [31:0] STR_SERVICE = 32'h40535251;
  localparam logic [31:0] STR_FIRE = 32'h40474554;
  localparam logic [31:0] STR_CLEAR = 32'h4044434c;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } dsp_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } dsp_rx_st_t;

  // Pins of one channel, at line level (high is logic zero).
  typedef struct packed {
    logic rxd;
    logic cts;
    logic dsr;
  } dsp_ser_in_t;

  typedef struct packed {
    logic txd;
    logic dtr;
    logic rts;
  } dsp_ser_out_t;

  // Complete state of one channel.
  typedef struct packed {
    logic [1:0] rxd_s;
    logic [1:0] cts_s;
    logic [1:0] dsr_s;
    logic rx_prev;
    logic [16:0] div_cnt;
    logic en;
    logic [2:0] baud;
    logic eight;
    logic [2:0] par;
    logic [1:0] stop;
    logic hwfc;
    dsp_tx_st_t tx_st;
    logic [5:0] tx_tick;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_pin;
    logic [7:0] hold;
    logic hold_v;
    logic srq_act;
    logic [1:0] srq_idx;
    logic flow_pend;
    logic flow_xoff;
    logic peer_xoff;
    dsp_rx_st_t rx_st;
    logic [5:0] rx_tick;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [7:0] rx_data;
    logic rx_v;
    logic perr;
    logic ferr;
    logic ovr;
    logic [31:0] hist;
  } dsp_ch_t;

  typedef struct packed {
    dsp_ch_t [1:0] ch;
    logic remote;
    logic trig;
    logic dclr;
    logic [31:0] prdata;
  } dsp_st_t;

  // Bit rate for each selector code.
  function automatic int unsigned baud_hz(input logic [2:0] sel);
    case (sel)
      3'h0: baud_hz = 110;
      3'h1: baud_hz = 300;
      3'h2: baud_hz = 600;
      3'h3: baud_hz = 1200;
      3'h4: baud_hz = 2400;
      3'h5: baud_hz = 4800;
      3'h6: baud_hz = 9600;
      default: baud_hz = 19200;
    endcase
  endfunction : baud_hz

  // Parity bit for a character; seven-bit characters carry bit 7 at zero.
  function automatic logic par_bit(input logic [2:0] m, input logic [7:0] d);
    case (m)
      PAR_EVEN: par_bit = ^d;
      PAR_ODD: par_bit = ~^d;
      PAR_ZERO: par_bit = 1'b0;
      default: par_bit = 1'b1;
    endcase
  endfunction : par_bit

endpackage : dsp_pkg

// file: dsp_remote_port.sv
// Two independent asynchronous serial remote-control channels with APB.
// Assumes one clock i_mclk, synchronous reset, and pins at line level.
//
// Overview of operation
// - Two independent channels, each switchable, both feed one command path.
// - Characters travel one bit at a time, least significant bit first.
// - Data lines are inverted: low line is logic one, high is zero.
// - Eight selectable bit rates from 110 to 19200 baud.
// - Characters carry seven or eight data bits.
// - Each frame opens with a start bit found by its falling edge.
// - Parity may be none, even, odd, forced zero or forced one.
// - Frames close with one, one and a half or two stop bits.
// - Remote string enters remote operation, manual string returns to local.
// - To ask for service the device sends the service string.
// - The fire string triggers a group execute action.
// - The clear string performs a device clear of command processing.
// - Received 11 hex enables character output, 13 hex inhibits it.
// - In software flow mode send XON when ready, XOFF when full.
// - The device stops sending data and service characters after a received XOFF until XON; XON and XOFF still go out.
// - With only data lines wired, only character flow control applies.
// - In hardware flow mode RTS sits at logic zero while switched on.
// - DTR shows receive readiness: logic zero ready, logic one not ready.
// - In hardware flow mode transmit only while CTS and DSR are both logic zero.
// - Carrier detect and ring indicator have no effect.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dsp_remote_port #(
  parameter int unsigned P_CLK_HZ = dsp_pkg::CLK_HZ
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire dsp_pkg::dsp_ser_in_t [1:0] i_ser,
  output dsp_pkg::dsp_ser_out_t [1:0] o_ser,
  output logic o_remote,
  output logic o_trigger,
  output logic o_dev_clear
);

  dsp_pkg::dsp_st_t s_q;
  dsp_pkg::dsp_st_t s_d;
  dsp_pkg::dsp_ch_t c;
  dsp_pkg::dsp_ch_t n;
  logic tick;
  logic go;
  logic allowed;
  logic start;
  logic rxl;
  logic rx_done;
  logic acc;
  logic hit;
  logic unmapped;
  logic [3:0] nbits;
  logic [7:0] tx_char;
  logic [7:0] rx_char;
  logic [31:0] hist_nx;

  // Divider limit for sixteen ticks per bit; never below one cycle.
  function automatic logic [16:0] div_lim(input logic [2:0] sel);
    int unsigned d;
    d = P_CLK_HZ / (dsp_pkg::OVS * dsp_pkg::baud_hz(sel));
    if (d < 1)
    begin
      d = 1;
    end
    div_lim = 17'(d - 1);
  endfunction : div_lim

  // Stop period length in oversample ticks.
  function automatic logic [5:0] stop_ticks(input logic [1:0] s);
    case (s)
      dsp_pkg::STOP_1: stop_ticks = dsp_pkg::TK_STOP_1;
      dsp_pkg::STOP_15: stop_ticks = dsp_pkg::TK_STOP_15;
      default: stop_ticks = dsp_pkg::TK_STOP_2;
    endcase
  endfunction : stop_ticks

  // Character of the service string at a given position.
  function automatic logic [7:0] srq_byte(input logic [1:0] i);
    case (i)
      2'h0: srq_byte = dsp_pkg::STR_SERVICE[31:24];
      2'h1: srq_byte = dsp_pkg::STR_SERVICE[23:16];
      2'h2: srq_byte = dsp_pkg::STR_SERVICE[15:8];
      default: srq_byte = dsp_pkg::STR_SERVICE[7:0];
    endcase
  endfunction : srq_byte

  // Read value of one register of one channel.
  function automatic logic [31:0] rd_word(input dsp_pkg::dsp_ch_t ch,
                                          input logic [3:0] off,
                                          input logic rem);
    logic [31:0] w;
    w = '0;
    case (off)
      dsp_pkg::OFF_CFG:
      begin
        w[dsp_pkg::CFG_EN] = ch.en;
        w[dsp_pkg::CFG_BAUD +: 3] = ch.baud;
        w[dsp_pkg::CFG_EIGHT] = ch.eight;
        w[dsp_pkg::CFG_PAR +: 3] = ch.par;
        w[dsp_pkg::CFG_STOP +: 2] = ch.stop;
        w[dsp_pkg::CFG_HW] = ch.hwfc;
      end
      dsp_pkg::OFF_RX: w[7:0] = ch.rx_data;
      dsp_pkg::OFF_STAT:
      begin
        w[dsp_pkg::ST_RXV] = ch.rx_v;
        w[dsp_pkg::ST_TXF] = ch.hold_v;
        w[dsp_pkg::ST_PERR] = ch.perr;
        w[dsp_pkg::ST_FERR] = ch.ferr;
        w[dsp_pkg::ST_OVR] = ch.ovr;
        w[dsp_pkg::ST_PXOFF] = ch.peer_xoff;
        w[dsp_pkg::ST_SRQ] = ch.srq_act;
        w[dsp_pkg::ST_REM] = rem;
      end
      default: w = '0;
    endcase
    rd_word = w;
  endfunction : rd_word

  // APB decode; the slave never inserts wait states.
  assign unmapped = (i_paddr[31:5] != '0) || (i_paddr[1:0] != 2'h0);
  assign acc = i_psel && i_penable && !unmapped;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && unmapped;
  assign o_prdata = s_q.prdata;
  assign o_remote = s_q.remote;
  assign o_trigger = s_q.trig;
  assign o_dev_clear = s_q.dclr;

  // Pin drivers; line high stands for logic zero.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      o_ser[i].txd = s_q.ch[i].tx_pin;
      o_ser[i].dtr = s_q.ch[i].en && !s_q.ch[i].rx_v;
      o_ser[i].rts = s_q.ch[i].en;
    end
  end

  // carrier detect and ring indicator are not wired to this block.
  // Next-state logic of both channels and the shared command events.
  always_comb
  begin
    s_d = s_q;
    s_d.trig = 1'b0;
    s_d.dclr = 1'b0;
    c = '0;
    n = '0;
    tick = 1'b0;
    go = 1'b0;
    allowed = 1'b0;
    start = 1'b0;
    rxl = 1'b1;
    rx_done = 1'b0;
    hit = 1'b0;
    nbits = 4'h8;
    tx_char = '0;
    rx_char = '0;
    hist_nx = '0;
    // the channels run side by side and share only the remote, trigger and clear state.
    for (int i = 0; i < 2; i++)
    begin
      c = s_q.ch[i];
      n = c;
      start = 1'b0;
      rx_done = 1'b0;
      tx_char = '0;
      // Two-stage synchronisers; only the second stage is used.
      n.rxd_s = {c.rxd_s[0], i_ser[i].rxd};
      n.cts_s = {c.cts_s[0], i_ser[i].cts};
      n.dsr_s = {c.dsr_s[0], i_ser[i].dsr};
      n.rx_prev = c.rxd_s[1];
      // logic level is the inverse of the line.
      rxl = !c.rxd_s[1];
      // sixteen ticks per bit at the selected rate.
      tick = c.en && (c.div_cnt == div_lim(c.baud));
      n.div_cnt = (tick || !c.en) ? '0 : c.div_cnt + 17'h00001;
      nbits = c.eight ? 4'h8 : 4'h7;
      // both handshake inputs at logic zero let data out.
      go = c.cts_s[1] && c.dsr_s[1];
      // peer XOFF holds data; hardware lines only in their mode.
      allowed = !c.peer_xoff && (!c.hwfc || go);
      if (tick)
      begin
        n.tx_tick = c.tx_tick + 6'h01;
        n.rx_tick = c.rx_tick + 6'h01;
      end

      // Transmitter: flow characters first, then service string, then data.
      case (c.tx_st)
        dsp_pkg::TX_IDLE:
        begin
          n.tx_pin = 1'b0;
          if (tick && !c.hwfc && c.flow_pend)
          begin
            tx_char = c.flow_xoff ? dsp_pkg::CHR_XOFF : dsp_pkg::CHR_XON;
            n.flow_pend = 1'b0;
            start = 1'b1;
          end
          else if (tick && allowed && c.srq_act)
          begin
            // service string goes out one character at a time.
            tx_char = srq_byte(c.srq_idx);
            n.srq_idx = c.srq_idx + 2'h1;
            n.srq_act = (c.srq_idx != 2'h3);
            start = 1'b1;
          end
          else if (tick && allowed && c.hold_v)
          begin
            tx_char = c.hold;
            n.hold_v = 1'b0;
            start = 1'b1;
          end
          if (start)
          begin
            n.tx_sh = c.eight ? tx_char : {1'b0, tx_char[6:0]};
            // parity worked out once per character.
            n.tx_par = dsp_pkg::par_bit(c.par, n.tx_sh);
            n.tx_st = dsp_pkg::TX_START;
            n.tx_tick = '0;
            // start bit is logic zero, a high line.
            n.tx_pin = 1'b1;
          end
        end
        dsp_pkg::TX_START:
        begin
          if (tick && c.tx_tick == dsp_pkg::TK_LAST)
          begin
            n.tx_st = dsp_pkg::TX_DATA;
            n.tx_tick = '0;
            n.tx_bit = '0;
            n.tx_pin = !c.tx_sh[0];
          end
        end
        dsp_pkg::TX_DATA:
        begin
          if (tick && c.tx_tick == dsp_pkg::TK_LAST)
          begin
            // shift right so the low bit leaves first.
            n.tx_sh = c.tx_sh >> 1;
            n.tx_tick = '0;
            n.tx_bit = c.tx_bit + 4'h1;
            n.tx_pin = !c.tx_sh[1];
            if (c.tx_bit == nbits - 4'h1)
            begin
              n.tx_st = (c.par == dsp_pkg::PAR_NONE) ? dsp_pkg::TX_STOP
                                                      : dsp_pkg::TX_PAR;
              n.tx_pin = (c.par == dsp_pkg::PAR_NONE) ? 1'b0 : !c.tx_par;
            end
          end
        end
        dsp_pkg::TX_PAR:
        begin
          if (tick && c.tx_tick == dsp_pkg::TK_LAST)
          begin
            n.tx_st = dsp_pkg::TX_STOP;
            n.tx_tick = '0;
            n.tx_pin = 1'b0;
          end
        end
        dsp_pkg::TX_STOP:
        begin
          // stop period of 16, 24 or 32 ticks.
          if (tick && c.tx_tick == stop_ticks(c.stop) - 6'h01)
          begin
            n.tx_st = dsp_pkg::TX_IDLE;
          end
        end
        default: n.tx_st = dsp_pkg::TX_IDLE;
      endcase

      // Receiver with start check at mid-bit and mid-bit sampling.
      case (c.rx_st)
        dsp_pkg::RX_IDLE:
        begin
          // falling edge of logic level opens a frame.
          if (c.en && !c.rx_prev && c.rxd_s[1])
          begin
            n.rx_st = dsp_pkg::RX_START;
            n.rx_tick = '0;
          end
        end
        dsp_pkg::RX_START:
        begin
          // confirm the start bit at its midpoint.
          if (tick && c.rx_tick == dsp_pkg::TK_MID)
          begin
            n.rx_st = rxl ? dsp_pkg::RX_IDLE : dsp_pkg::RX_DATA;
            n.rx_tick = '0;
            n.rx_bit = '0;
          end
        end
        dsp_pkg::RX_DATA:
        begin
          if (tick && c.rx_tick == dsp_pkg::TK_LAST)
          begin
            // first bit in ends up lowest.
            n.rx_sh = {rxl, c.rx_sh[7:1]};
            n.rx_tick = '0;
            n.rx_bit = c.rx_bit + 4'h1;
            if (c.rx_bit == nbits - 4'h1)
            begin
              n.rx_st = (c.par == dsp_pkg::PAR_NONE) ? dsp_pkg::RX_STOP
                                                      : dsp_pkg::RX_PAR;
            end
          end
        end
        dsp_pkg::RX_PAR:
        begin
          if (tick && c.rx_tick == dsp_pkg::TK_LAST)
          begin
            n.rx_par = rxl;
            n.rx_st = dsp_pkg::RX_STOP;
            n.rx_tick = '0;
          end
        end
        dsp_pkg::RX_STOP:
        begin
          if (tick && c.rx_tick == dsp_pkg::TK_LAST)
          begin
            n.rx_st = dsp_pkg::RX_IDLE;
            rx_done = 1'b1;
          end
        end
        default: n.rx_st = dsp_pkg::RX_IDLE;
      endcase
      rx_char = c.eight ? c.rx_sh : {1'b0, c.rx_sh[7:1]};

      // Register access; clears come before hardware sets so sets win.
      hit = acc && (i_paddr[dsp_pkg::CH_SEL_BIT] == 1'(i));
      if (hit && i_pwrite)
      begin
        case (i_paddr[3:0])
          dsp_pkg::OFF_CFG:
          begin
            n.en = i_pwdata[dsp_pkg::CFG_EN];
            n.baud = i_pwdata[dsp_pkg::CFG_BAUD +: 3];
            n.eight = i_pwdata[dsp_pkg::CFG_EIGHT];
            n.par = i_pwdata[dsp_pkg::CFG_PAR +: 3];
            n.stop = i_pwdata[dsp_pkg::CFG_STOP +: 2];
            n.hwfc = i_pwdata[dsp_pkg::CFG_HW];
            // announce readiness when switched on in software mode.
            if (!c.en && i_pwdata[dsp_pkg::CFG_EN] &&
                !i_pwdata[dsp_pkg::CFG_HW])
            begin
              n.flow_pend = 1'b1;
              n.flow_xoff = 1'b0;
            end
          end
          dsp_pkg::OFF_TX:
          begin
            // A write while the holding byte is full is dropped.
            if (!c.hold_v)
            begin
              n.hold = i_pwdata[7:0];
              n.hold_v = 1'b1;
            end
          end
          dsp_pkg::OFF_STAT:
          begin
            n.perr = c.perr && !i_pwdata[dsp_pkg::ST_PERR];
            n.ferr = c.ferr && !i_pwdata[dsp_pkg::ST_FERR];
            n.ovr = c.ovr && !i_pwdata[dsp_pkg::ST_OVR];
            if (i_pwdata[dsp_pkg::ST_SRQ_GO] && !c.srq_act)
            begin
              n.srq_act = 1'b1;
              n.srq_idx = '0;
            end
          end
          default: n.en = c.en;
        endcase
      end
      if (hit && !i_pwrite && i_paddr[3:0] == dsp_pkg::OFF_RX)
      begin
        n.rx_v = 1'b0;
        if (!c.hwfc)
        begin
          n.flow_pend = 1'b1;
          n.flow_xoff = 1'b0;
        end
      end

      // Delivery of a received character.
      if (rx_done)
      begin
        // A clear in this cycle stands unless a new error arrives with it.
        n.ferr = n.ferr || !rxl;
        if (c.par != dsp_pkg::PAR_NONE &&
            c.rx_par != dsp_pkg::par_bit(c.par, rx_char))
        begin
          n.perr = 1'b1;
        end
        // flow characters steer output and are not stored.
        if (rx_char == dsp_pkg::CHR_XON)
        begin
          n.peer_xoff = 1'b0;
        end
        else if (rx_char == dsp_pkg::CHR_XOFF)
        begin
          n.peer_xoff = 1'b1;
        end
        else
        begin
          n.ovr = n.ovr || n.rx_v;
          n.rx_data = rx_char;
          n.rx_v = 1'b1;
          // one-byte buffer now full, ask the peer to pause.
          if (!c.hwfc)
          begin
            n.flow_pend = 1'b1;
            n.flow_xoff = 1'b1;
          end
          hist_nx = {c.hist[23:0], rx_char};
          n.hist = hist_nx;
          if (hist_nx == dsp_pkg::STR_REMOTE)
          begin
            s_d.remote = 1'b1;
          end
          if (hist_nx == dsp_pkg::STR_MANUAL)
          begin
            s_d.remote = 1'b0;
          end
          if (hist_nx == dsp_pkg::STR_FIRE)
          begin
            s_d.trig = 1'b1;
          end
          // clear drops pending input and string history.
          if (hist_nx == dsp_pkg::STR_CLEAR)
          begin
            s_d.dclr = 1'b1;
            n.hist = '0;
            n.rx_v = 1'b0;
          end
        end
      end

      // A switched-off channel idles at mark with no flow character pending.
      if (!n.en)
      begin
        n.tx_st = dsp_pkg::TX_IDLE;
        n.rx_st = dsp_pkg::RX_IDLE;
        n.tx_pin = 1'b0;
        n.flow_pend = 1'b0;
      end
      s_d.ch[i] = n;
    end
    // Read data is captured in the setup phase, ready in the access phase.
    if (i_psel && !i_penable && !i_pwrite)
    begin
      s_d.prdata = unmapped ? '0 :
                   rd_word(s_q.ch[i_paddr[dsp_pkg::CH_SEL_BIT]],
                           i_paddr[3:0], s_q.remote);
    end
  end

  // synchronous reset returns everything to zero: idle, mark, cleared.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  a_txd_mark_off: assert property (!s_q.ch[0].en |-> !o_ser[0].txd)
    else $error("Switched-off channel is not at mark.");
  a_rts_level_on: assert property (
    s_q.ch[0].en && s_q.ch[0].hwfc |-> o_ser[0].rts)
    else $error("RTS not active while channel is on.");
  a_dtr_not_ready: assert property (
    s_q.ch[0].rx_v |-> !o_ser[0].dtr)
    else $error("DTR shows ready with a full buffer.");
  a_hw_gate_hold: assert property (
    s_q.ch[0].tx_st == dsp_pkg::TX_IDLE && s_q.ch[0].hwfc &&
    !(s_q.ch[0].cts_s[1] && s_q.ch[0].dsr_s[1])
    |=> s_q.ch[0].tx_st == dsp_pkg::TX_IDLE)
    else $error("Frame started without CTS and DSR.");
  a_xoff_hold: assert property (
    s_q.ch[0].tx_st == dsp_pkg::TX_IDLE && !s_q.ch[0].hwfc &&
    s_q.ch[0].peer_xoff && !s_q.ch[0].flow_pend
    |=> s_q.ch[0].tx_st == dsp_pkg::TX_IDLE)
    else $error("Data sent after peer XOFF.");
  a_xoff_queued: assert property (
    $rose(s_q.ch[0].rx_v) && !s_q.ch[0].hwfc && s_q.ch[0].en
    |-> s_q.ch[0].flow_pend && s_q.ch[0].flow_xoff)
    else $error("No XOFF queued when buffer filled.");
  a_start_bit: assert property (
    s_q.ch[0].tx_st == dsp_pkg::TX_IDLE ##1
    s_q.ch[0].tx_st == dsp_pkg::TX_START |-> o_ser[0].txd)
    else $error("Start bit is not a high line.");
  a_lsb_first: assert property (
    s_q.ch[0].tx_st == dsp_pkg::TX_START ##1
    s_q.ch[0].tx_st == dsp_pkg::TX_DATA
    |-> o_ser[0].txd == !$past(s_q.ch[0].tx_sh[0]))
    else $error("First data bit is not the LSB.");
  a_trig_pulse: assert property (o_trigger |=> !o_trigger)
    else $error("Trigger pulse longer than one cycle.");
  a_unmapped_err: assert property (
    i_psel && i_penable && i_paddr[31:5] != '0 |-> o_pslverr)
    else $error("Unmapped access not flagged.");

endmodule : dsp_remote_port

// file: dsp_ctrl_model.sv
// Controller on the far side of one serial channel: 8 data bits, no parity.
// Assumes line-level pins, where a high line carries logic zero.
`timescale 1ns/1ps
module dsp_ctrl_model #(
  parameter int BIT = 64
) (
  input wire logic i_mclk,
  input wire logic i_hold,
  input wire dsp_pkg::dsp_ser_out_t i_dev,
  output dsp_pkg::dsp_ser_in_t o_line
);
  logic rxd = 1'b0;
  logic paused = 1'b0;

  // ready lines: held off means both lines at logic one (line low).
  assign o_line = '{rxd, !i_hold, !i_hold};

  // frame out, start then data from the low bit.
  task automatic send(input logic [7:0] c);
    // a paused controller waits for XON, and for DTR as well.
    wait (!paused && i_dev.dtr === 1'b1);
    @(posedge i_mclk);
    rxd <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge i_mclk);
      rxd <= ~c[i];
    end
    repeat (BIT) @(posedge i_mclk);
    rxd <= 1'b0;
    repeat (2 * BIT) @(posedge i_mclk);
  endtask : send

  // frame in, sampled mid-bit after the start edge.
  task automatic recv(output logic [7:0] c);
    wait (i_dev.txd === 1'b1);
    repeat (BIT / 2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge i_mclk);
      c[i] = ~i_dev.txd;
    end
    // track the device's own XON and XOFF characters.
    if (c == dsp_pkg::CHR_XOFF)
      paused = 1'b1;
    else if (c == dsp_pkg::CHR_XON)
      paused = 1'b0;
    repeat (BIT) @(posedge i_mclk);
  endtask : recv
endmodule : dsp_ctrl_model

// file: dsp_remote_port_tb.sv
// Self-checking bench for the serial port; channel zero carries traffic.
// Assumes a slowed clock parameter giving 64 clocks a bit at 19200 baud.
`timescale 1ns/1ps
module dsp_remote_port_tb;
  localparam int BIT = 64;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic hold = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic remote;
  logic trig;
  logic dclr;
  logic [7:0] b;
  int errors = 0;
  int n_tests = 0;
  int n_trig = 0;
  int n_clr = 0;
  dsp_pkg::dsp_ser_in_t m_line;
  dsp_pkg::dsp_ser_out_t [1:0] ser_out;
  logic [31:0] strs [4] = '{dsp_pkg::STR_REMOTE, dsp_pkg::STR_MANUAL,
    dsp_pkg::STR_FIRE, dsp_pkg::STR_CLEAR};
  logic [31:0] evs [4] = '{32'h10, 32'h0, 32'h4, 32'h5};

  dsp_remote_port #(.P_CLK_HZ(1228800)) u_dsp_remote_port (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_ser({3'b011, m_line}), .o_ser(ser_out), .o_remote(remote),
    .o_trigger(trig), .o_dev_clear(dclr));
  dsp_ctrl_model #(.BIT(BIT)) u_dsp_ctrl_model (.i_mclk(i_mclk),
    .i_hold(hold), .i_dev(ser_out[0]), .o_line(m_line));

  // Free-running 200 MHz clock.
  initial forever #2.5 i_mclk = ~i_mclk;

  // Count strobe cycles, so a strobe held as a level shows as a surplus.
  always @(posedge i_mclk)
  begin
    n_trig <= n_trig + int'(trig);
    n_clr <= n_clr + int'(dclr);
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; a read is compared when a name is given.
  task automatic acc(input logic w, input logic [31:0] a, d, input string nm);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1)
      @(posedge i_mclk);
    if (nm != "")
      chk(nm, d, prdata);
    chk("slverr", 32'(a > 32'h1f), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Main sequence: every step waits for the previous one to finish, except the forked send and receive pairs.
  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    chk("lines", 32'h0, {29'h0, ser_out[0]});
    acc(1'b0, 32'h0, 32'h0, "cfg");
    acc(1'b0, 32'h40, 32'h0, "unmapped");
    acc(1'b1, 32'h0, 32'h41f, "");
    repeat (2) @(posedge i_mclk);
    chk("lines", 32'h3, {29'h0, ser_out[0]});
    acc(1'b1, 32'h4, 32'h41, "");
    u_dsp_ctrl_model.recv(b);
    chk("tx", 32'h41, {24'h0, b});
    hold <= 1'b1;
    acc(1'b1, 32'h4, 32'h33, "");
    repeat (4 * BIT) @(posedge i_mclk);
    chk("lines", 32'h3, {29'h0, ser_out[0]});
    acc(1'b0, 32'hc, 32'h2, "stat");
    hold <= 1'b0;
    u_dsp_ctrl_model.recv(b);
    chk("tx", 32'h33, {24'h0, b});
    u_dsp_ctrl_model.send(8'h5a);
    chk("lines", 32'h1, {29'h0, ser_out[0]});
    acc(1'b0, 32'hc, 32'h1, "stat");
    acc(1'b0, 32'h8, 32'h5a, "rx");
    for (int s = 0; s < 4; s++)
    begin
      for (int k = 3; k >= 0; k--)
      begin
        u_dsp_ctrl_model.send(strs[s][8 * k +: 8]);
        acc(1'b0, 32'h8, 32'h0, "");
      end
      chk("events", evs[s], {27'h0, remote, 2'(n_trig), 2'(n_clr)});
    end
    acc(1'b1, 32'hc, 32'h100, "");
    for (int k = 3; k >= 0; k--)
    begin
      u_dsp_ctrl_model.recv(b);
      chk("srq", {24'h0, dsp_pkg::STR_SERVICE[8 * k +: 8]}, {24'h0, b});
    end
    // Software flow mode from here on: XON on enable, XOFF when full.
    acc(1'b1, 32'h0, 32'h0, "");
    acc(1'b1, 32'h0, 32'h1f, "");
    u_dsp_ctrl_model.recv(b);
    chk("xon", 32'h11, {24'h0, b});
    fork
      u_dsp_ctrl_model.send(8'h2a);
      u_dsp_ctrl_model.recv(b);
    join
    chk("xoff", 32'h13, {24'h0, b});
    acc(1'b0, 32'h8, 32'h2a, "rx");
    u_dsp_ctrl_model.recv(b);
    chk("xon", 32'h11, {24'h0, b});
    u_dsp_ctrl_model.send(dsp_pkg::CHR_XOFF);
    acc(1'b0, 32'hc, 32'h20, "stat");
    acc(1'b1, 32'h4, 32'h77, "");
    repeat (4 * BIT) @(posedge i_mclk);
    chk("lines", 32'h3, {29'h0, ser_out[0]});
    fork
      u_dsp_ctrl_model.send(dsp_pkg::CHR_XON);
      u_dsp_ctrl_model.recv(b);
    join
    chk("tx", 32'h77, {24'h0, b});
    conclude();
  end

  // Watchdog well beyond the roughly 21000 cycles the sequence needs.
  initial
  begin
    repeat (80000) @(posedge i_mclk);
    errors++;
    conclude();
  end
endmodule : dsp_remote_port_tb
